//--- hdl/ssig_pkg.sv
package ssig_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int FS_PRE_DOWN_US = 20;
  localparam int FS_DEBOUNCE_US = 20;
  localparam int FS_HWD_RELEASE_US = 30;
  localparam int FS_PRE_DOWN_CYC = (FS_PRE_DOWN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FS_DEBOUNCE_CYC = (FS_DEBOUNCE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FS_HWD_RELEASE_CYC =
      (FS_HWD_RELEASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FS_CNT_W = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Host link
  localparam logic [6:0] I2C_ADDR_BASE = 7'h08;
  localparam logic [6:0] I2C_ADDR_CFG = 7'h08;
  localparam logic [7:0] CRC_POLY = 8'h1D;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [3:0] I2C_BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] BYTE_ADDR = 3'h0;
  localparam logic [2:0] BYTE_REG = 3'h1;
  localparam logic [2:0] BYTE_DATA = 3'h2;
  localparam logic [2:0] BYTE_CRC = 3'h3;
  localparam logic [2:0] BYTE_EXTRA = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Flag positions in the clear strobe vector
  localparam int FLG_SAFE = 0;
  localparam int FLG_WDI = 1;
  localparam int FLG_SFAULT = 2;
  // Position of the hard watchdog cause in the fault vector
  localparam int CAUSE_HWD = 5;
  localparam int CAUSE_W = 6;

  typedef enum logic [2:0] {
    FS_OFF,
    FS_START,
    FS_RUN,
    FS_PRE,
    FS_DOWN,
    FS_HWD
  } ssig_fs_e;

endpackage

//--- hdl/ssig_sync2.sv
`timescale 1ns/1ps
module ssig_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ssig_sync_s;

  ssig_sync_s st_r;
  ssig_sync_s st_nxt;

  if (W < 1) begin : g_bad_width
    $error("bad width");
  end

  // Only the second stage is visible outside
  always_comb begin
    st_nxt.meta = i_async;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_r <= {RST_VAL, RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sync = st_r.stable;
endmodule

//--- hdl/ssig_crc8.sv
`timescale 1ns/1ps
module ssig_crc8 (
  input wire logic [7:0] i_crc,
  input wire logic [7:0] i_data,
  output logic [7:0] o_crc
);
  import ssig_pkg::*;

  // One byte, MSB first, no reflection and no final inversion
  always_comb begin
    o_crc = i_crc ^ i_data;
    for (int k = 0; k < 8; k++) begin
      if (o_crc[7]) begin
        o_crc = {o_crc[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        o_crc = {o_crc[6:0], 1'b0};
      end
    end
  end
endmodule

//--- hdl/ssig_top.sv
// Behaviour
// [R1] Active-safe fuse: pin low from fuse load while safe.
// [R2] Safe entry: self-test, enabled flags, hard reset, off with reset.
// [R3] Each safe entry drives pin low and sets safe flag.
// [R4] Exit only: host reset high, no faults, flags clear.
// [R5] Soft watchdog reset drives pin only if input enable set.
// [R6] Soft-fault enable: OV, UV, current limit drive pin at once.
// [R7] Config pin high: configuration mode; low: normal.
// [R8] Configuration mode answers on fixed address 0x08.
// [R9] Configuration mode disables all watchdog operation; code still lets i_hard_wdog_reset enter safe state.
// [R10] Config mode without power-up: no CRC, no secure write.
// [R11] Fail-sync fuse clear: pin ignored.
// [R12] Internal fault: fail-sync low 20 us before power-down.
// [R13] Listed fault causes assert fail-sync on power-down.
// [R14] Fail-sync held low throughout off mode.
// [R15] External low held 20 us in system-on: fail event.
// [R16] Power-on releases fail-sync; peer low pauses power-up.
// [R17] Hard watchdog: release after 30 us, reload fuses.
// [R18] Slave address is 0x08 plus 3-bit fuse field.
// [R19] Byte latched after bit eight; shorter fragment dropped, no ack.
// [R20] CRC fuse set: verify each transaction.
// [R21] CRC mismatch: drop command, maskable CRC interrupt.
// [R22] CRC is 8-bit polynomial 0x1D, preset 0xFF per transaction.
// [R23] Pin released when flags clear or supply undervoltage.
// [R24] Not-ok flags clear on write one; zero keeps.
// [R25] CRC over address, register, data; CRC byte follows.
// [R26] 20 and 30 us intervals counted on system clock.
`timescale 1ns/1ps
module ssig_top #(
  parameter int PRE_DOWN_CYC = ssig_pkg::FS_PRE_DOWN_CYC,
  parameter int DEBOUNCE_CYC = ssig_pkg::FS_DEBOUNCE_CYC,
  parameter int HWD_RELEASE_CYC = ssig_pkg::FS_HWD_RELEASE_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_fuse_loaded,
  input wire logic i_active_safe_mode_fuse,
  input wire logic i_fail_sync_enable_fuse,
  input wire logic i_crc_enable_fuse,
  input wire logic [2:0] i_i2c_addr_fuse,
  input wire logic i_config_mode_pin,
  input wire logic i_host_reset_n,
  input wire logic i_analog_self_test_fail,
  input wire logic i_regulator_fault,
  input wire logic i_soft_fault,
  input wire logic i_wdog_input_event,
  input wire logic i_soft_wdog_reset,
  input wire logic i_hard_wdog_reset,
  input wire logic i_off_mode,
  input wire logic i_vin_uvdet,
  input wire logic i_wdog_input_safety_enable,
  input wire logic i_soft_fault_safety_enable,
  input wire logic [2:0] i_flag_clear,
  input wire logic i_power_on_request,
  input wire logic [ssig_pkg::CAUSE_W-1:0] i_fault_off_cause,
  input wire logic i_power_down_done,
  input wire logic i_fail_sync_n_i,
  input wire logic i_scl,
  input wire logic i_sda_i,
  input wire logic i_crc_irq_mask,
  input wire logic i_crc_irq_clear,
  output logic o_safety_output_n_o,
  output logic o_safety_output_n_oe,
  output logic o_safe_state,
  output logic o_safe_state_not_ok_flag,
  output logic o_wdog_input_not_ok_flag,
  output logic o_soft_fault_not_ok_flag,
  output logic o_try_before_burn_mode,
  output logic o_wdog_disable,
  output logic o_secure_write_disable,
  output logic o_fail_sync_n_o,
  output logic o_fail_sync_n_oe,
  output logic o_power_down_start,
  output logic o_power_up_hold,
  output logic o_reload_fuses,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic o_wr_valid,
  output logic [7:0] o_wr_reg,
  output logic [7:0] o_wr_data,
  output logic o_crc_irq_flag,
  output logic o_irq_out_n
);
  import ssig_pkg::*;

  if (PRE_DOWN_CYC < 1 || PRE_DOWN_CYC >= (1 << FS_CNT_W) ||
      DEBOUNCE_CYC < 1 || DEBOUNCE_CYC >= (1 << FS_CNT_W) ||
      HWD_RELEASE_CYC < 1 || HWD_RELEASE_CYC >= (1 << FS_CNT_W)) begin : g_bad_count
    $error("interval count out of range");
  end

  localparam logic [FS_CNT_W-1:0] PRE_LAST = FS_CNT_W'(PRE_DOWN_CYC - 1);
  localparam logic [FS_CNT_W-1:0] DEB_LAST = FS_CNT_W'(DEBOUNCE_CYC - 1);
  localparam logic [FS_CNT_W-1:0] REL_LAST = FS_CNT_W'(HWD_RELEASE_CYC - 1);

  typedef struct packed {
    logic loaded_d;
    logic safe;
    logic ass_nok;
    logic wdi_nok;
    logic sf_nok;
    logic safe_drive;
    ssig_fs_e fs;
    logic fs_hwd;
    logic [FS_CNT_W-1:0] fs_cnt;
    logic fs_drive;
    logic pd_start;
    logic reload;
    logic hold;
    logic scl_d;
    logic sda_d;
    logic i2c_on;
    logic sel;
    logic acking;
    logic ack_drive;
    logic [3:0] bitcnt;
    logic [2:0] bidx;
    logic [7:0] sh;
    logic [7:0] crc;
    logic [7:0] reg_b;
    logic [7:0] data_b;
    logic wr_valid;
    logic [7:0] wr_reg;
    logic [7:0] wr_data;
    logic crc_err;
    logic irq_n;
  } ssig_st_s;

  localparam ssig_st_s ST_RST = '{fs: FS_OFF, crc: CRC_INIT, fs_drive: 1'b1, irq_n: 1'b1,
                                  scl_d: 1'b1, sda_d: 1'b1, default: '0};

  ssig_st_s st_r;
  ssig_st_s st_nxt;

  logic [3:0] pins_s;
  logic cfg_s;
  logic fs_pin_s;
  logic scl_s;
  logic sda_s;
  logic [7:0] crc_next;
  logic [6:0] my_addr;
  logic crc_active;
  logic load_rise;
  logic enter_ev;
  logic exit_ok;
  logic wdi_set;
  logic sf_set;
  logic ext_low;
  logic fault_ev;
  logic scl_rise;
  logic scl_fall;
  logic i2c_start;
  logic i2c_stop;
  logic byte_done;
  logic crc_bad;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and CRC step
  ssig_sync2 #(
    .W(4),
    .RST_VAL(4'h7)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_async({i_config_mode_pin, i_fail_sync_n_i, i_scl, i_sda_i}),
    .o_sync(pins_s)
  );

  assign cfg_s = pins_s[3];
  assign fs_pin_s = pins_s[2];
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  ssig_crc8 u_crc (
    .i_crc(st_r.crc),
    .i_data(st_r.sh),
    .o_crc(crc_next)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.pd_start = 1'b0;
    st_nxt.reload = 1'b0;
    st_nxt.wr_valid = 1'b0;
    st_nxt.loaded_d = i_fuse_loaded;
    my_addr = cfg_s ? I2C_ADDR_CFG : (I2C_ADDR_BASE | {4'h0, i_i2c_addr_fuse}); // [R8] [R18]
    crc_active = i_crc_enable_fuse & ~(cfg_s & ~i_power_on_request); // [R10] [R20]
    load_rise = i_fuse_loaded & ~st_r.loaded_d;

    // Safety output and its not-ok flags; a set in the clear cycle wins
    wdi_set = i_wdog_input_safety_enable & ~cfg_s &
              (i_wdog_input_event | i_soft_wdog_reset); // [R5] [R9]
    sf_set = i_soft_fault_safety_enable & i_soft_fault; // [R6]
    st_nxt.wdi_nok = wdi_set | (st_r.wdi_nok & ~i_flag_clear[FLG_WDI]); // [R24]
    st_nxt.sf_nok = sf_set | (st_r.sf_nok & ~i_flag_clear[FLG_SFAULT]); // [R24]
    enter_ev = i_active_safe_mode_fuse & st_r.loaded_d &
               (i_analog_self_test_fail |
                (st_r.wdi_nok & i_wdog_input_safety_enable) |
                (st_r.sf_nok & i_soft_fault_safety_enable) |
                i_hard_wdog_reset |
                (i_off_mode & ~i_host_reset_n)); // [R2]
    st_nxt.ass_nok = enter_ev | (st_r.ass_nok & ~i_flag_clear[FLG_SAFE]); // [R3] [R24]
    exit_ok = i_host_reset_n & ~i_analog_self_test_fail & ~i_regulator_fault &
              ~st_nxt.wdi_nok & ~st_nxt.sf_nok & ~st_nxt.ass_nok; // [R4]
    if (!i_active_safe_mode_fuse) begin
      st_nxt.safe = 1'b0;
    end else if (load_rise || enter_ev || st_r.ass_nok) begin
      st_nxt.safe = 1'b1; // [R1] [R3]
    end else if (exit_ok) begin
      st_nxt.safe = 1'b0; // [R4]
    end
    // Undervoltage lets the pin go but keeps the flags for software
    st_nxt.safe_drive = (st_nxt.safe | st_nxt.ass_nok | st_nxt.wdi_nok | st_nxt.sf_nok) &
                        ~i_vin_uvdet; // [R23]

    // Fail-sync sequencing
    ext_low = i_fail_sync_enable_fuse & ~fs_pin_s; // [R11]
    fault_ev = |i_fault_off_cause; // [R13]
    unique case (st_r.fs)
      FS_OFF: begin
        st_nxt.fs_cnt = '0;
        if (i_power_on_request) begin
          st_nxt.fs = FS_START; // [R16]
        end
      end
      FS_START: begin
        if (!ext_low) begin
          st_nxt.fs = FS_RUN; // [R16]
        end
      end
      FS_RUN: begin
        if (i_off_mode) begin
          st_nxt.fs = FS_OFF;
        end else if (fault_ev) begin
          st_nxt.fs_hwd = i_fault_off_cause[CAUSE_HWD];
          st_nxt.fs_cnt = '0;
          if (i_fail_sync_enable_fuse) begin
            st_nxt.fs = FS_PRE; // [R12] [R13]
          end else begin
            st_nxt.fs = FS_DOWN;
            st_nxt.pd_start = 1'b1;
          end
        end else if (ext_low) begin
          if (st_r.fs_cnt == DEB_LAST) begin
            st_nxt.fs = FS_DOWN; // [R15]
            st_nxt.fs_hwd = 1'b0;
            st_nxt.pd_start = 1'b1;
          end else begin
            st_nxt.fs_cnt = st_r.fs_cnt + 1'b1; // [R26]
          end
        end else begin
          st_nxt.fs_cnt = '0;
        end
      end
      FS_PRE: begin
        if (st_r.fs_cnt == PRE_LAST) begin
          st_nxt.fs = FS_DOWN; // [R12]
          st_nxt.pd_start = 1'b1;
        end else begin
          st_nxt.fs_cnt = st_r.fs_cnt + 1'b1; // [R26]
        end
      end
      FS_DOWN: begin
        st_nxt.fs_cnt = '0;
        if (i_power_down_done) begin
          st_nxt.fs = st_r.fs_hwd ? FS_HWD : FS_OFF;
        end
      end
      FS_HWD: begin
        if (st_r.fs_cnt == REL_LAST) begin
          st_nxt.fs = FS_START; // [R17]
          st_nxt.reload = 1'b1;
        end else begin
          st_nxt.fs_cnt = st_r.fs_cnt + 1'b1; // [R26]
        end
      end
    endcase
    st_nxt.fs_drive = (st_nxt.fs != FS_START) && (st_nxt.fs != FS_RUN); // [R14]
    st_nxt.hold = (st_nxt.fs == FS_START) & ext_low; // [R16]

    // Host link slave, sampled from the synchronised pins
    st_nxt.scl_d = scl_s;
    st_nxt.sda_d = sda_s;
    scl_rise = scl_s & ~st_r.scl_d;
    scl_fall = ~scl_s & st_r.scl_d;
    i2c_start = scl_s & st_r.scl_d & st_r.sda_d & ~sda_s;
    i2c_stop = scl_s & st_r.scl_d & ~st_r.sda_d & sda_s;
    byte_done = 1'b0;
    crc_bad = 1'b0;
    if (i2c_start) begin
      st_nxt.i2c_on = 1'b1;
      st_nxt.sel = 1'b0;
      st_nxt.bidx = BYTE_ADDR;
      st_nxt.bitcnt = '0;
      st_nxt.acking = 1'b0;
      st_nxt.ack_drive = 1'b0;
      st_nxt.crc = CRC_INIT; // [R22]
    end else if (i2c_stop) begin
      // A fragment short of eight bits is simply dropped here
      st_nxt.i2c_on = 1'b0;
      st_nxt.bitcnt = '0; // [R19]
      st_nxt.acking = 1'b0;
      st_nxt.ack_drive = 1'b0;
    end else if (st_r.i2c_on) begin
      if (scl_rise && !st_r.acking && st_r.bitcnt < I2C_BITS_PER_BYTE) begin
        st_nxt.sh = {st_r.sh[6:0], sda_s};
        st_nxt.bitcnt = st_r.bitcnt + 1'b1;
      end
      if (scl_fall && st_r.acking) begin
        st_nxt.acking = 1'b0;
        st_nxt.ack_drive = 1'b0;
      end else if (scl_fall && st_r.bitcnt == I2C_BITS_PER_BYTE) begin
        byte_done = 1'b1; // [R19]
        st_nxt.bitcnt = '0;
        st_nxt.acking = 1'b1;
        st_nxt.ack_drive = 1'b0;
        if (st_r.bidx != BYTE_EXTRA) begin
          st_nxt.bidx = st_r.bidx + 1'b1;
        end
        unique case (st_r.bidx)
          BYTE_ADDR: begin
            if (st_r.sh[7:1] == my_addr && !st_r.sh[0]) begin
              st_nxt.sel = 1'b1;
              st_nxt.ack_drive = 1'b1;
              st_nxt.crc = crc_next; // [R25]
            end
          end
          BYTE_REG: begin
            if (st_r.sel) begin
              st_nxt.reg_b = st_r.sh;
              st_nxt.ack_drive = 1'b1;
              st_nxt.crc = crc_next; // [R25]
            end
          end
          BYTE_DATA: begin
            if (st_r.sel) begin
              st_nxt.data_b = st_r.sh;
              st_nxt.ack_drive = 1'b1;
              st_nxt.crc = crc_next; // [R25]
              if (!crc_active) begin
                st_nxt.wr_valid = 1'b1; // [R20]
                st_nxt.wr_reg = st_r.reg_b;
                st_nxt.wr_data = st_r.sh;
              end
            end
          end
          BYTE_CRC: begin
            if (st_r.sel && crc_active) begin
              st_nxt.ack_drive = 1'b1;
              if (st_r.sh == st_r.crc) begin
                st_nxt.wr_valid = 1'b1; // [R20]
                st_nxt.wr_reg = st_r.reg_b;
                st_nxt.wr_data = st_r.data_b;
              end else begin
                crc_bad = 1'b1; // [R21]
              end
            end
          end
          default: begin
            st_nxt.ack_drive = 1'b0;
          end
        endcase
      end
    end
    st_nxt.crc_err = crc_bad | (st_r.crc_err & ~i_crc_irq_clear); // [R21]
    st_nxt.irq_n = ~(st_nxt.crc_err & ~i_crc_irq_mask); // [R21]
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_safety_output_n_o = 1'b0;
  assign o_safety_output_n_oe = st_r.safe_drive;
  assign o_safe_state = st_r.safe;
  assign o_safe_state_not_ok_flag = st_r.ass_nok;
  assign o_wdog_input_not_ok_flag = st_r.wdi_nok;
  assign o_soft_fault_not_ok_flag = st_r.sf_nok;
  assign o_try_before_burn_mode = cfg_s; // [R7]
  assign o_wdog_disable = cfg_s; // [R9]
  assign o_secure_write_disable = cfg_s & ~i_power_on_request; // [R10]
  assign o_fail_sync_n_o = 1'b0;
  // Gated by the fuse so a disabled link never loads a shared wire
  assign o_fail_sync_n_oe = i_fail_sync_enable_fuse & st_r.fs_drive; // [R11] [R14]
  assign o_power_down_start = st_r.pd_start;
  assign o_power_up_hold = st_r.hold;
  assign o_reload_fuses = st_r.reload;
  assign o_sda_o = 1'b0;
  assign o_sda_oe = st_r.ack_drive;
  assign o_wr_valid = st_r.wr_valid;
  assign o_wr_reg = st_r.wr_reg;
  assign o_wr_data = st_r.wr_data;
  assign o_crc_irq_flag = st_r.crc_err;
  assign o_irq_out_n = st_r.irq_n;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  safe_entry_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [R3]
    enter_ev && !i_vin_uvdet |=> o_safe_state && o_safe_state_not_ok_flag && o_safety_output_n_oe)
    else $error("safe entry missed");
  nok_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [R24]
    o_safe_state_not_ok_flag && !i_flag_clear[FLG_SAFE] |=> o_safe_state_not_ok_flag)
    else $error("safe flag lost");
  soft_fault_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [R6]
    i_soft_fault && i_soft_fault_safety_enable && !i_vin_uvdet |=> o_safety_output_n_oe)
    else $error("soft fault missed");
  exit_block_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [R4]
    i_active_safe_mode_fuse && o_safe_state && !i_host_reset_n |=> o_safe_state)
    else $error("early safe exit");
  addr_sel_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [R8]
    cfg_s |-> my_addr == 7'h08 && o_wdog_disable)
    else $error("config mode wrong");
  crc_off_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [R10]
    cfg_s && !i_power_on_request |-> !crc_active && o_secure_write_disable)
    else $error("CRC not disabled");
  pre_down_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [R12]
    o_power_down_start && $past(st_r.fs) == FS_PRE |->
      $past(st_r.fs_cnt) == PRE_LAST && $past(o_fail_sync_n_oe))
    else $error("lead time short");
  debounce_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [R15]
    o_power_down_start && $past(st_r.fs) == FS_RUN && !$past(fault_ev) |->
      $past(st_r.fs_cnt) == DEB_LAST && o_fail_sync_n_oe)
    else $error("debounce short");
  off_low_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [R14]
    i_fail_sync_enable_fuse && st_r.fs == FS_OFF |-> o_fail_sync_n_oe)
    else $error("off release");
  fs_ignore_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [R11]
    !i_fail_sync_enable_fuse |-> !o_fail_sync_n_oe && !ext_low)
    else $error("fail-sync not ignored");
  crc_bad_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [R21]
    crc_bad |=> o_crc_irq_flag && !o_wr_valid ##0 (o_irq_out_n == $past(i_crc_irq_mask)))
    else $error("CRC error missed");
endmodule

//--- test/ssig_i2c_host.sv
`timescale 1ns/1ps
module ssig_i2c_host (
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  localparam realtime H = 62.5;
  initial begin
    o_scl = 1'h1;
    o_sda_low = 1'h0;
  end
  task automatic start();
    o_sda_low = 1'h1;
    #H o_scl = 1'h0;
  endtask
  // SDA moves only while SCL is low
  task automatic xfer(input logic [7:0] d, input int nb, output logic ack);
    for (int i = 7; i > 7 - nb; i--) begin
      #(H / 2) o_sda_low = !d[i];
      #(H / 2) o_scl = 1'h1;
      #H o_scl = 1'h0;
    end
    ack = 1'h0;
    if (nb == 8) begin
      #(H / 2) o_sda_low = 1'h0;
      #(H / 2) o_scl = 1'h1;
      #(H - 1) ack = !i_sda;
      #1 o_scl = 1'h0;
    end
  endtask
  task automatic stop();
    #(H / 2) o_sda_low = 1'h1;
    #(H / 2) o_scl = 1'h1;
    #H o_sda_low = 1'h0;
    #H;
  endtask
endmodule

//--- test/test_ssig_top.sv
`timescale 1ns/1ps
module test_ssig_top;
  import ssig_pkg::*;
  localparam int PD = 20;
  localparam int DB = 20;
  localparam int HR = 30;
  logic i_clk_sys, i_rst, i_fuse_loaded, i_active_safe_mode_fuse, i_fail_sync_enable_fuse;
  logic i_crc_enable_fuse, i_config_mode_pin, i_host_reset_n, i_analog_self_test_fail;
  logic i_regulator_fault, i_soft_fault, i_wdog_input_event, i_soft_wdog_reset;
  logic i_hard_wdog_reset, i_off_mode, i_vin_uvdet, i_wdog_input_safety_enable;
  logic i_soft_fault_safety_enable, i_power_on_request, i_power_down_done, i_fail_sync_n_i;
  logic i_scl, i_sda_i, i_crc_irq_mask, i_crc_irq_clear, peer_low, host_low;
  logic [2:0] i_i2c_addr_fuse, i_flag_clear;
  logic [CAUSE_W-1:0] i_fault_off_cause;
  logic o_safety_output_n_o, o_safety_output_n_oe, o_safe_state, o_safe_state_not_ok_flag;
  logic o_wdog_input_not_ok_flag, o_soft_fault_not_ok_flag, o_try_before_burn_mode;
  logic o_wdog_disable, o_secure_write_disable, o_fail_sync_n_o, o_fail_sync_n_oe;
  logic o_power_down_start, o_power_up_hold, o_reload_fuses, o_sda_o, o_sda_oe, o_wr_valid;
  logic o_crc_irq_flag, o_irq_out_n;
  logic [7:0] o_wr_reg, o_wr_data, c;
  logic [3:0] a;
  int num_errors, cmp_count, i;
  int ev[3];
  ssig_top #(.PRE_DOWN_CYC(PD), .DEBOUNCE_CYC(DB), .HWD_RELEASE_CYC(HR)) dut (.*);
  ssig_i2c_host host (.i_sda(i_sda_i), .o_scl(i_scl), .o_sda_low(host_low));
  // Open-drain wires
  assign i_sda_i = !(host_low || (o_sda_oe && !o_sda_o));
  assign i_fail_sync_n_i = !(peer_low || (o_fail_sync_n_oe && !o_fail_sync_n_o));
  initial begin
    i_clk_sys = 1'h0;
    forever #5 i_clk_sys = !i_clk_sys;
  end
  // Count one-cycle pulses
  always @(negedge i_clk_sys) begin
    ev[0] += int'(o_wr_valid === 1'h1);
    ev[1] += int'(o_power_down_start === 1'h1);
    ev[2] += int'(o_reload_fuses === 1'h1);
  end
  ////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wait_ev(input int k, output int n);
    int b;
    b = ev[k];
    for (n = 1; n <= 200; n++) begin
      settle(1);
      if (ev[k] != b) return;
    end
    num_errors++;
    final_report();
  endtask
  function automatic logic [7:0] crc8(input logic [23:0] m);
    logic [7:0] r;
    r = 8'hFF;
    for (int j = 23; j >= 0; j--) r = {r[6:0], 1'h0} ^ ((r[7] ^ m[j]) ? 8'h1D : 8'h00);
    return r;
  endfunction
  task automatic send(input logic [31:0] w, input int n, input int last, input logic [3:0] ea,
                      input int ew);
    logic k;
    int e;
    e = ev[0];
    a = 4'h0;
    host.start();
    for (int j = 0; j < n; j++) begin
      host.xfer(w[31-8*j -: 8], (j == n - 1) ? last : 8, k);
      a[3-j] = k;
    end
    host.stop();
    settle(20);
    chk(a, ea);
    chk(ev[0] - e, ew);
  endtask
  ////////////////////////////////////////////////
  initial begin
    i_rst = 1'h1;
    {i_fuse_loaded, i_active_safe_mode_fuse, i_crc_enable_fuse, i_config_mode_pin} = 4'h0;
    {i_analog_self_test_fail, i_regulator_fault, i_soft_fault, i_wdog_input_event} = 4'h0;
    {i_soft_wdog_reset, i_hard_wdog_reset, i_off_mode, i_vin_uvdet} = 4'h0;
    {i_wdog_input_safety_enable, i_soft_fault_safety_enable, i_power_down_done} = 3'h0;
    {i_crc_irq_mask, i_crc_irq_clear, peer_low, i_power_on_request} = 4'h0;
    {i_fail_sync_enable_fuse, i_host_reset_n, i_i2c_addr_fuse, i_flag_clear} = 8'hE8;
    i_fault_off_cause = '0;
    num_errors = 0;
    cmp_count = 0;
    ev = '{0, 0, 0};
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 1'h0;
    settle(3);
    chk(o_fail_sync_n_oe, 1);
    @(posedge i_clk_sys) peer_low <= 1'h1;
    @(posedge i_clk_sys) i_power_on_request <= 1'h1;
    settle(10);
    chk({o_power_up_hold, o_fail_sync_n_oe}, 2'h2);
    @(posedge i_clk_sys) peer_low <= 1'h0;
    settle(10);
    chk(o_power_up_hold, 0);
    for (int b = 0; b < CAUSE_W; b++) begin
      @(posedge i_clk_sys) i_fault_off_cause <= CAUSE_W'(1) << b;
      @(posedge i_clk_sys) i_fault_off_cause <= '0;
      wait_ev(1, i);
      chk(i, PD + 1);
      chk(o_fail_sync_n_oe, 1);
      @(posedge i_clk_sys) i_power_down_done <= 1'h1;
      if (b == CAUSE_HWD) begin
        wait_ev(2, i);
        chk(i >= HR && i <= HR + 6, 1);
        chk(o_fail_sync_n_oe, 0);
      end
      @(posedge i_clk_sys) i_power_down_done <= 1'h0;
      settle(10);
      chk(o_fail_sync_n_oe, 0);
    end
    @(posedge i_clk_sys) peer_low <= 1'h1;
    wait_ev(1, i);
    chk(i >= DB && i <= DB + 6, 1);
    chk(o_fail_sync_n_oe, 1);
    @(posedge i_clk_sys) peer_low <= 1'h0;
    @(posedge i_clk_sys) i_power_down_done <= 1'h1;
    @(posedge i_clk_sys) i_power_down_done <= 1'h0;
    @(posedge i_clk_sys) i_fail_sync_enable_fuse <= 1'h0;
    @(posedge i_clk_sys) peer_low <= 1'h1;
    i = ev[1];
    settle(DB + 10);
    chk(ev[1], i);
    chk(o_fail_sync_n_oe, 0);
    @(posedge i_clk_sys) peer_low <= 1'h0;
    @(posedge i_clk_sys) i_fail_sync_enable_fuse <= 1'h1;
    $display("fail-sync test done");
    @(posedge i_clk_sys) i_soft_fault_safety_enable <= 1'h1;
    @(posedge i_clk_sys) i_soft_fault <= 1'h1;
    @(posedge i_clk_sys) i_soft_fault <= 1'h0;
    settle(3);
    chk({o_soft_fault_not_ok_flag, o_safety_output_n_oe, o_safety_output_n_o}, 3'h6);
    @(posedge i_clk_sys) i_flag_clear <= 3'h4;
    @(posedge i_clk_sys) i_flag_clear <= 3'h0;
    settle(2);
    chk({o_soft_fault_not_ok_flag, o_safety_output_n_oe}, 2'h0);
    @(posedge i_clk_sys) i_soft_wdog_reset <= 1'h1;
    @(posedge i_clk_sys) i_soft_wdog_reset <= 1'h0;
    settle(2);
    chk(o_safety_output_n_oe, 0);
    @(posedge i_clk_sys) i_wdog_input_safety_enable <= 1'h1;
    @(posedge i_clk_sys) i_soft_wdog_reset <= 1'h1;
    @(posedge i_clk_sys) i_soft_wdog_reset <= 1'h0;
    settle(2);
    chk(o_safety_output_n_oe, 1);
    @(posedge i_clk_sys) i_vin_uvdet <= 1'h1;
    settle(2);
    chk(o_safety_output_n_oe, 0);
    @(posedge i_clk_sys) i_vin_uvdet <= 1'h0;
    @(posedge i_clk_sys) i_flag_clear <= 3'h7;
    @(posedge i_clk_sys) i_flag_clear <= 3'h0;
    @(posedge i_clk_sys) i_host_reset_n <= 1'h0;
    @(posedge i_clk_sys) i_active_safe_mode_fuse <= 1'h1;
    @(posedge i_clk_sys) i_fuse_loaded <= 1'h1;
    settle(3);
    chk({o_safe_state, o_safety_output_n_oe}, 2'h3);
    @(posedge i_clk_sys) i_host_reset_n <= 1'h1;
    settle(3);
    chk({o_safe_state, o_safety_output_n_oe}, 2'h0);
    @(posedge i_clk_sys) i_hard_wdog_reset <= 1'h1;
    @(posedge i_clk_sys) i_hard_wdog_reset <= 1'h0;
    settle(5);
    chk({o_safe_state, o_safe_state_not_ok_flag, o_safety_output_n_oe}, 3'h7);
    @(posedge i_clk_sys) i_flag_clear <= 3'h1;
    @(posedge i_clk_sys) i_flag_clear <= 3'h0;
    settle(3);
    chk({o_safe_state, o_safe_state_not_ok_flag, o_safety_output_n_oe}, 3'h0);
    $display("safety test done");
    send({8'h1A, 8'h12, 8'h34, 8'h00}, 3, 8, 4'hE, 1);
    chk({o_wr_reg, o_wr_data}, 16'h1234);
    send({8'h18, 8'h12, 8'h34, 8'h00}, 3, 8, 4'h0, 0);
    send({8'h1A, 8'h56, 8'h00, 8'h00}, 2, 7, 4'h8, 0);
    @(posedge i_clk_sys) i_crc_enable_fuse <= 1'h1;
    c = crc8(24'h1A5678);
    send({24'h1A5678, c}, 4, 8, 4'hF, 1);
    chk({o_wr_reg, o_wr_data, o_crc_irq_flag, o_irq_out_n}, 18'h159E1);
    c = ~crc8(24'h1A9ABC);
    send({24'h1A9ABC, c}, 4, 8, 4'hF, 0);
    chk({o_crc_irq_flag, o_irq_out_n}, 2'h2);
    @(posedge i_clk_sys) i_crc_irq_mask <= 1'h1;
    settle(2);
    chk(o_irq_out_n, 1);
    @(posedge i_clk_sys) i_crc_irq_clear <= 1'h1;
    @(posedge i_clk_sys) i_crc_irq_clear <= 1'h0;
    settle(2);
    chk(o_crc_irq_flag, 0);
    $display("host link test done");
    @(posedge i_clk_sys) i_config_mode_pin <= 1'h1;
    settle(5);
    chk({o_try_before_burn_mode, o_wdog_disable, o_secure_write_disable}, 3'h6);
    @(posedge i_clk_sys) i_wdog_input_event <= 1'h1;
    @(posedge i_clk_sys) i_wdog_input_event <= 1'h0;
    settle(3);
    chk(o_wdog_input_not_ok_flag, 0);
    @(posedge i_clk_sys) i_power_on_request <= 1'h0;
    settle(5);
    chk(o_secure_write_disable, 1);
    send({8'h10, 8'h21, 8'h43, 8'h00}, 3, 8, 4'hE, 1);
    send({8'h1A, 8'h21, 8'h43, 8'h00}, 3, 8, 4'h0, 0);
    $display("config test done");
    final_report();
  end
endmodule
